// [ctc_pkg.sv]
// Package of constants and types for the conversion threshold compare block.
package ctc_pkg;
   localparam int DATA_W = 24;
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] ADDR_SLOT7_LOW = 8'h27;
   localparam logic [ADDR_W-1:0] ADDR_SLOT0_HIGH = 8'h28;
   localparam logic [ADDR_W-1:0] ADDR_SLOT1_HIGH = 8'h29;
   localparam logic [ADDR_W-1:0] ADDR_SLOT2_HIGH = 8'h2A;
   localparam logic [DATA_W-1:0] LIMIT_RESET = 24'h000000;
   localparam logic [DATA_W-1:0] DATA_ZERO = 24'h000000;
   localparam int MSB = DATA_W - 1;

   // One register access from the serial control interface.
   typedef struct packed {
      logic wr;
      logic rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } ctc_req_s;

   // One result write from the conversion engine.
   typedef struct packed {
      logic [3:0] slot_we;
      logic [DATA_W-1:0] data;
   } ctc_res_s;

   // Coding selection shared by the results and the limits.
   typedef struct packed {
      logic unipolar_bipolar_select;
      logic offset_binary_format;
   } ctc_cfg_s;
endpackage : ctc_pkg

// [ctc_cmp.sv]
// Coded magnitude comparator used for each limit check.
`timescale 1ns/1ps
module ctc_cmp (
   // Operands.
   input wire logic [ctc_pkg::DATA_W-1:0] a_i,
   input wire logic [ctc_pkg::DATA_W-1:0] b_i,
   // Coding.
   input wire ctc_pkg::ctc_cfg_s cfg_i,
   // Result.
   output logic a_lt_b_o
);
   // Map a code onto an unsigned scale so one compare serves all codings.
   function automatic logic [ctc_pkg::DATA_W-1:0] ord_key(
      input logic [ctc_pkg::DATA_W-1:0] v, input ctc_pkg::ctc_cfg_s c);
      logic [ctc_pkg::DATA_W-1:0] k;
      k = v;
      // Two's complement bipolar data needs its sign bit flipped; unipolar
      // and offset binary codes already order as unsigned numbers.
      if (c.unipolar_bipolar_select && !c.offset_binary_format) begin
         k[ctc_pkg::MSB] = ~v[ctc_pkg::MSB];
      end
      return k;
   endfunction : ord_key

   // Limits use the same coding as results, so both pass one map.
   always_comb begin
      a_lt_b_o = ord_key(a_i, cfg_i) < ord_key(b_i, cfg_i);
   end
endmodule : ctc_cmp

// [ctc_top.sv]
// Limit registers and range flags for result slots 0, 1, 2 and 7.
`timescale 1ns/1ps
module ctc_top (
   // Clock and reset.
   input wire logic mclk_i,
   input wire logic rst_i,
   // Register access.
   input wire ctc_pkg::ctc_req_s req_i,
   output logic [ctc_pkg::DATA_W-1:0] rdata_o,
   output logic rvalid_o,
   // Results: slot_we bit 0..2 = slots 0..2, bit 3 = slot 7.
   input wire ctc_pkg::ctc_res_s res_i,
   input wire ctc_pkg::ctc_cfg_s cfg_i,
   // Range flags.
   output logic slot7_under_range_flag_o,
   output logic slot0_over_range_flag_o,
   output logic slot1_over_range_flag_o,
   output logic slot2_over_range_flag_o
);
   typedef struct packed {
      logic [ctc_pkg::DATA_W-1:0] slot7_low_limit;
      logic [ctc_pkg::DATA_W-1:0] slot0_high_limit;
      logic [ctc_pkg::DATA_W-1:0] slot1_high_limit;
      logic [ctc_pkg::DATA_W-1:0] slot2_high_limit;
      logic [ctc_pkg::DATA_W-1:0] result_slot_0;
      logic [ctc_pkg::DATA_W-1:0] result_slot_1;
      logic [ctc_pkg::DATA_W-1:0] result_slot_2;
      logic [ctc_pkg::DATA_W-1:0] result_slot_7;
      logic [ctc_pkg::DATA_W-1:0] rdata;
      logic rvalid;
   } ctc_state_s;

   ctc_state_s st_q;
   ctc_state_s st_d;
   logic lt7;
   logic lt0;
   logic lt1;
   logic lt2;

   // Slot 7: result below low limit means under range.
   ctc_cmp u_cmp7 (
      .a_i(st_q.result_slot_7), .b_i(st_q.slot7_low_limit), .cfg_i(cfg_i), .a_lt_b_o(lt7));
   // Slots 0 to 2: limit below result means over range.
   ctc_cmp u_cmp0 (
      .a_i(st_q.slot0_high_limit), .b_i(st_q.result_slot_0), .cfg_i(cfg_i), .a_lt_b_o(lt0));
   ctc_cmp u_cmp1 (
      .a_i(st_q.slot1_high_limit), .b_i(st_q.result_slot_1), .cfg_i(cfg_i), .a_lt_b_o(lt1));
   ctc_cmp u_cmp2 (
      .a_i(st_q.slot2_high_limit), .b_i(st_q.result_slot_2), .cfg_i(cfg_i), .a_lt_b_o(lt2));

   // Flags follow stored values, so they update the cycle after a new result
   // or limit lands; software must rewrite limits after a coding change.
   assign slot7_under_range_flag_o = lt7;
   assign slot0_over_range_flag_o = lt0;
   assign slot1_over_range_flag_o = lt1;
   assign slot2_over_range_flag_o = lt2;
   assign rdata_o = st_q.rdata;
   assign rvalid_o = st_q.rvalid;

   // Next state: limit writes, result captures and read data.
   always_comb begin
      st_d = st_q;
      st_d.rvalid = req_i.rd;
      if (req_i.wr) begin
         case (req_i.addr)
            ctc_pkg::ADDR_SLOT7_LOW: st_d.slot7_low_limit = req_i.wdata;
            ctc_pkg::ADDR_SLOT0_HIGH: st_d.slot0_high_limit = req_i.wdata;
            ctc_pkg::ADDR_SLOT1_HIGH: st_d.slot1_high_limit = req_i.wdata;
            ctc_pkg::ADDR_SLOT2_HIGH: st_d.slot2_high_limit = req_i.wdata;
            default: st_d.rdata = st_q.rdata;
         endcase
      end
      if (req_i.rd) begin
         // Unmapped addresses read as zero.
         case (req_i.addr)
            ctc_pkg::ADDR_SLOT7_LOW: st_d.rdata = st_q.slot7_low_limit;
            ctc_pkg::ADDR_SLOT0_HIGH: st_d.rdata = st_q.slot0_high_limit;
            ctc_pkg::ADDR_SLOT1_HIGH: st_d.rdata = st_q.slot1_high_limit;
            ctc_pkg::ADDR_SLOT2_HIGH: st_d.rdata = st_q.slot2_high_limit;
            default: st_d.rdata = ctc_pkg::DATA_ZERO;
         endcase
      end
      // Each new result triggers a fresh comparison.
      if (res_i.slot_we[0]) begin
         st_d.result_slot_0 = res_i.data;
      end
      if (res_i.slot_we[1]) begin
         st_d.result_slot_1 = res_i.data;
      end
      if (res_i.slot_we[2]) begin
         st_d.result_slot_2 = res_i.data;
      end
      if (res_i.slot_we[3]) begin
         st_d.result_slot_7 = res_i.data;
      end
   end

   // State register with synchronous reset.
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         st_q <= '{slot7_low_limit: ctc_pkg::LIMIT_RESET, slot0_high_limit: ctc_pkg::LIMIT_RESET,
                   slot1_high_limit: ctc_pkg::LIMIT_RESET, slot2_high_limit: ctc_pkg::LIMIT_RESET,
                   result_slot_0: ctc_pkg::DATA_ZERO, result_slot_1: ctc_pkg::DATA_ZERO,
                   result_slot_2: ctc_pkg::DATA_ZERO, result_slot_7: ctc_pkg::DATA_ZERO,
                   rdata: ctc_pkg::DATA_ZERO, rvalid: 1'b0};
      end else begin
         st_q <= st_d;
      end
   end
endmodule : ctc_top

// [ctc_top_sva.sv]
// Port assertions for the threshold compare block.
`timescale 1ns/1ps
module ctc_top_sva (
   // Clock and reset.
   input wire logic mclk_i,
   input wire logic rst_i,
   // Watched ports.
   input wire ctc_pkg::ctc_req_s req_i,
   input wire logic [ctc_pkg::DATA_W-1:0] rdata_o,
   input wire logic rvalid_o,
   input wire ctc_pkg::ctc_res_s res_i,
   input wire ctc_pkg::ctc_cfg_s cfg_i,
   input wire logic slot7_under_range_flag_o,
   input wire logic slot0_over_range_flag_o,
   input wire logic slot1_over_range_flag_o,
   input wire logic slot2_over_range_flag_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   // The four flags as one vector, and whether the address names a limit.
   wire logic [3:0] fl = {slot7_under_range_flag_o, slot0_over_range_flag_o,
      slot1_over_range_flag_o, slot2_over_range_flag_o};
   wire logic mapped = req_i.addr inside {[8'h27:8'h2A]};
   a_read_answer: assert property (req_i.rd |=> rvalid_o) else $error("no answer");
   a_no_answer: assert property (!req_i.rd |=> !rvalid_o) else $error("stray answer");
   a_rdata_hold: assert property (!req_i.rd |=> $stable(rdata_o)) else $error("data moved");
   a_unmapped_zero: assert property (req_i.rd && !mapped |=> rdata_o == 24'h000000)
      else $error("unmapped read");
   a_write_readback: assert property (req_i.wr && mapped ##1 req_i.rd && !req_i.wr &&
      $stable(req_i.addr) |=> rdata_o == $past(req_i.wdata, 2)) else $error("readback");
   a_reset_clear: assert property ($past(rst_i) |-> fl == 4'h0) else $error("flag after reset");
   a_flag_cause: assert property ($changed(fl) |-> $changed(cfg_i) ||
      $past(req_i.wr || (|res_i.slot_we))) else $error("flag moved");
   a_signed_over: assert property (req_i.wr && req_i.addr == 8'h28 ##1 !req_i.wr ##1
      res_i.slot_we[0] && !req_i.wr && cfg_i == 2'b10 |=> $changed(cfg_i) || slot0_over_range_flag_o
      == ($signed($past(res_i.data)) > $signed($past(req_i.wdata, 3)))) else $error("signed");
endmodule : ctc_top_sva

bind ctc_top ctc_top_sva chk (.mclk_i(mclk_i), .rst_i(rst_i), .req_i(req_i), .rdata_o(rdata_o),
   .rvalid_o(rvalid_o), .res_i(res_i), .cfg_i(cfg_i),
   .slot7_under_range_flag_o(slot7_under_range_flag_o),
   .slot0_over_range_flag_o(slot0_over_range_flag_o),
   .slot1_over_range_flag_o(slot1_over_range_flag_o),
   .slot2_over_range_flag_o(slot2_over_range_flag_o));

// [ctc_host.sv]
// Host software model that issues register accesses.
`timescale 1ns/1ps
module ctc_host (
   // Clock.
   input wire logic mclk_i,
   // Requests.
   output ctc_pkg::ctc_req_s req_o
);
   initial req_o = '0;
   // One access per edge; a following call overwrites it, so back-to-back needs no gap.
   task automatic acc(input logic w, input logic [7:0] a, input logic [23:0] d);
      @(posedge mclk_i) req_o <= '{wr: w, rd: !w, addr: a, wdata: d};
   endtask : acc
   task automatic idle;
      @(posedge mclk_i) req_o <= '0;
   endtask : idle
endmodule : ctc_host

// [tb_conversion_threshold_compare.sv]
// Self-checking bench for the threshold compare block.
`timescale 1ns/1ps
module tb_conversion_threshold_compare;
   logic mclk_i = 1'b0;
   logic rst_i = 1'b1;
   ctc_pkg::ctc_req_s req;
   ctc_pkg::ctc_res_s res = '0;
   ctc_pkg::ctc_cfg_s cfg = '0;
   logic [23:0] rdata;
   logic rvalid, f7, f0, f1, f2;
   int err_total = 0;
   int tests_run = 0;
   // A 50 MHz clock.
   always #10 mclk_i = ~mclk_i;
   ctc_host host (.mclk_i(mclk_i), .req_o(req));
   ctc_top uut (.mclk_i(mclk_i), .rst_i(rst_i), .req_i(req), .rdata_o(rdata), .rvalid_o(rvalid),
      .res_i(res), .cfg_i(cfg), .slot7_under_range_flag_o(f7), .slot0_over_range_flag_o(f0),
      .slot1_over_range_flag_o(f1), .slot2_over_range_flag_o(f2));
   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // Read and compare; the answer lands one edge after the strobe.
   task automatic rd(input logic [7:0] a, input logic [23:0] e);
      host.acc(1'b0, a, 24'h000000);
      host.idle;
      #1 chk(24'(rvalid), 24'h000001);
      chk(rdata, e);
   endtask : rd
   // Load one result into the slots in the mask, then let flags settle.
   task automatic ld(input logic [3:0] m, input logic [23:0] d);
      @(posedge mclk_i) res <= '{slot_we: m, data: d};
      @(posedge mclk_i) res <= '0;
      #1;
   endtask : ld
   task automatic t_regs;
      for (int i = 0; i < 4; i++) begin
         rd(8'(8'h27 + i), 24'h000000);
         host.acc(1'b1, 8'(8'h27 + i), 24'hA5C3F0 ^ 24'(i));
         rd(8'(8'h27 + i), 24'hA5C3F0 ^ 24'(i));
      end
      host.acc(1'b1, 8'h2B, 24'hFFFFFF);
      rd(8'h2B, 24'h000000);
      rd(8'h26, 24'h000000);
   endtask : t_regs
   // Equal values raise nothing; one step past each limit raises every flag.
   task automatic t_flags;
      for (int i = 0; i < 4; i++) host.acc(1'b1, 8'(8'h27 + i), 24'h000100);
      host.idle;
      ld(4'hF, 24'h000100);
      chk(24'({f7, f0, f1, f2}), 24'h000000);
      ld(4'h7, 24'h000101);
      ld(4'h8, 24'h0000FF);
      chk(24'({f7, f0, f1, f2}), 24'h00000F);
   endtask : t_flags
   // A negative two's complement result stays under a small positive limit.
   task automatic t_code;
      @(posedge mclk_i) cfg <= '{1'b1, 1'b0};
      host.acc(1'b1, 8'h28, 24'h000010);
      host.idle;
      ld(4'h1, 24'hFFFFF0);
      chk(24'(f0), 24'h000000);
      @(posedge mclk_i) cfg <= '{1'b1, 1'b1};
      #1 chk(24'(f0), 24'h000001);
   endtask : t_code
   task automatic summarize;
      $display("errors %0d checks %0d", err_total, tests_run);
      if (err_total == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : summarize
   initial begin
      repeat (12) @(posedge mclk_i);
      rst_i <= 1'b0;
      t_regs;
      t_flags;
      t_code;
      summarize;
   end
endmodule : tb_conversion_threshold_compare
